// *** pmc_pkg.sv ***
/*
 * pmc_pkg: shared constants and types of the power mode controller.
 * assumes a single 100 MHz pclk that keeps running in every power state.
 */
package pmc_pkg;

   // ************************************************************
   // clock and timing
   // ************************************************************
   localparam int CLK_FREQ_KHZ = 100_000;
   localparam int POR_TIME_MS = 128;
   localparam int POR_CYCLES = POR_TIME_MS * CLK_FREQ_KHZ;

   // ************************************************************
   // register map (byte offsets) and field positions
   // ************************************************************
   localparam logic [7:0] OFS_POWER_CTRL = 8'h00;
   localparam logic [7:0] OFS_PLL_CTRL = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam int BIT_IDLE_REQ = 0;
   localparam int BIT_PDOWN_REQ = 1;
   localparam int BIT_SERIAL_WAKE = 2;
   localparam int BIT_EXT_WAKE = 3;
   localparam int BIT_OSC_HALT = 0;
   localparam int BIT_TIC_EN = 1;
   localparam logic [31:0] POWER_CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] PLL_CTRL_RESET = 32'h0000_0000;

   // ************************************************************
   // types
   // ************************************************************
   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_IDLE = 2'b01,
      MODE_PDOWN = 2'b10
   } pmc_mode_type;

   typedef enum logic [1:0] {
      CAUSE_NONE = 2'b00,
      CAUSE_IRQ = 2'b01,
      CAUSE_TIC = 2'b10,
      CAUSE_PIN = 2'b11
   } pmc_cause_type;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pmc_apb_req_type;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pmc_apb_rsp_type;

   typedef struct packed {
      logic core_clk_en;
      logic periph_clk_en;
      logic pll_en;
      logic osc_en;
      logic tic_clk_en;
      logic port_hold;
      logic dac_hiz;
      logic core_rst_n;
      logic resume;
   } pmc_power_out_type;

   typedef struct packed {
      logic irq_any;
      logic tic_irq;
      logic serial_irq;
      logic external_interrupt_zero_n;
      logic reset_pin_n;
   } pmc_wake_in_type;

endpackage

// *** pmc_por_timer.sv ***
/*
 * pmc_por_timer: power-on reset hold and release timer.
 * assumes supply comparator levels arrive synchronous to pclk.
 */
`timescale 1ns/1ns
`default_nettype none

module pmc_por_timer #(
   parameter int POR_CYCLES = pmc_pkg::POR_CYCLES
) (
   input wire logic pclk,              // system clock
   input wire logic presetn,           // async reset, active low
   input wire logic supply_above_hi,   // digital supply above 2.45 V
   input wire logic supply_above_lo,   // digital supply above 1 V
   output logic por_busy               // reset held by power-on logic
);
   import pmc_pkg::*;

   localparam int CW = $clog2(POR_CYCLES + 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic busy;
   } pmc_por_state_type;

   pmc_por_state_type s_q, s_d;

   // the early release check below watches eight cycles of hold
   if (POR_CYCLES < 9) begin : g_bad_cycles
      $error("pmc_por_timer: POR_CYCLES must be at least 9");
   end

   // ************************************************************
   // hold while supply is low, then count out the release delay
   // ************************************************************
   always_comb begin
      s_d = s_q;
      if (!supply_above_hi || !supply_above_lo) begin
         // falling supply keeps reset asserted all the way down to 1 V
         s_d.busy = 1'b1;
         s_d.cnt = '0;
      end else if (s_q.busy) begin
         // release only after the full interval above threshold
         if (s_q.cnt == CW'(POR_CYCLES - 1)) begin
            s_d.busy = 1'b0;
         end else begin
            s_d.cnt = s_q.cnt + CW'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{cnt: '0, busy: 1'b1};
      end else begin
         s_q <= s_d;
      end
   end

   assign por_busy = s_q.busy;

   // ************************************************************
   // checks
   // ************************************************************
   property p_por_low_holds;
      @(posedge pclk) disable iff (!presetn)
      !supply_above_hi |=> por_busy;
   endproperty
   a_por_low_holds: assert property (p_por_low_holds)
      else $error("reset not held with supply below threshold");

   property p_por_no_early_release;
      @(posedge pclk) disable iff (!presetn)
      $rose(supply_above_hi) && supply_above_lo |=> por_busy [*8];
   endproperty
   a_por_no_early_release: assert property (p_por_no_early_release)
      else $error("power-on reset released too early");

endmodule

`default_nettype wire

// *** pmc_power_mode_controller.sv ***
/*
 * pmc_power_mode_controller: normal, idle and power-down control with an
 * APB register slave and the power-on reset timer.
 * assumes pclk is an always-on clock and interrupt inputs are synchronous.
 */
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

// Overview of operation
// - a software write selects idle mode or full power-down from normal
// - idle keeps the oscillator running and gates the core clock
// - idle keeps peripheral clocks running
// - idle asserts no reset, so core registers are kept
// - idle holds port pins and converter outputs at their entry state; the code raises only port_hold in idle and keeps dac_hiz low
// - any enabled interrupt or a hardware reset ends idle
// - power-down stops the PLL and the core clock
// - power-down halts the oscillator only when the halt bit is set
// - the interval counter clock may keep running in power-down
// - all other peripherals lose their clock in power-down
// - power-down holds port levels and makes the converter output high-z
// - reset pin ends power-down, defaults all registers, core restarts
// - power cycling defaults registers and restarts after the por delay
// - interval counter interrupt wakes from power-down without reset
// - serial interrupt wakes power-down only with its wake enable set
// - interrupt zero wakes power-down only with its wake enable set
// - power-on reset holds below threshold, then times out before release
// - on falling supply reset stays held down to the lower level
module pmc_power_mode_controller #(
   parameter int POR_CYCLES = pmc_pkg::POR_CYCLES
) (
   input wire logic pclk,                         // system clock, 100 MHz
   input wire logic presetn,                      // async reset, active low
   input wire pmc_pkg::pmc_apb_req_type apb_req,  // apb request group
   output pmc_pkg::pmc_apb_rsp_type apb_rsp,      // apb response group
   input wire pmc_pkg::pmc_wake_in_type wake_in,  // wake and reset sources
   input wire logic supply_above_hi,              // supply above 2.45 V
   input wire logic supply_above_lo,              // supply above 1 V
   output pmc_pkg::pmc_power_out_type pwr_out     // clock gates and holds
);
   import pmc_pkg::*;

   typedef struct packed {
      pmc_mode_type mode;
      logic idle_req;
      logic pdown_req;
      logic serial_wake_enable;
      logic ext_int_zero_wake_enable;
      logic oscillator_halt_bit;
      logic tic_en;
      pmc_cause_type cause;
      pmc_apb_rsp_type rsp;
      pmc_power_out_type pwr;
   } pmc_state_type;

   pmc_state_type s_q, s_d;
   logic por_busy;
   logic soft_rst;
   logic setup_ph;
   logic access_ph;
   logic mapped;
   logic pdown_wake;
   logic [31:0] power_control_reg;
   logic [31:0] pll_control_reg;
   logic [31:0] status_reg;

   // ************************************************************
   // power-on reset timer
   // ************************************************************
   pmc_por_timer #(
      .POR_CYCLES(POR_CYCLES)
   ) u_por (
      .pclk(pclk),
      .presetn(presetn),
      .supply_above_hi(supply_above_hi),
      .supply_above_lo(supply_above_lo),
      .por_busy(por_busy)
   );

   // ************************************************************
   // register views and decode
   // ************************************************************
   // por or the reset pin both return every register to its default
   assign soft_rst = por_busy || !wake_in.reset_pin_n;
   assign setup_ph = apb_req.psel && !apb_req.penable;
   assign access_ph = apb_req.psel && apb_req.penable;
   assign mapped = (apb_req.paddr == OFS_POWER_CTRL) ||
                   (apb_req.paddr == OFS_PLL_CTRL) ||
                   (apb_req.paddr == OFS_STATUS);

   always_comb begin
      power_control_reg = POWER_CTRL_RESET;
      power_control_reg[BIT_IDLE_REQ] = s_q.idle_req;
      power_control_reg[BIT_PDOWN_REQ] = s_q.pdown_req;
      power_control_reg[BIT_SERIAL_WAKE] = s_q.serial_wake_enable;
      power_control_reg[BIT_EXT_WAKE] = s_q.ext_int_zero_wake_enable;
      pll_control_reg = PLL_CTRL_RESET;
      pll_control_reg[BIT_OSC_HALT] = s_q.oscillator_halt_bit;
      pll_control_reg[BIT_TIC_EN] = s_q.tic_en;
      status_reg = {26'h000_0000, s_q.cause, por_busy, 1'b0, s_q.mode};
   end

   // power-down wake sources; interrupt zero is level sensitive, so a low
   // level around entry would wake at once: the source keeps it high
   assign pdown_wake = (wake_in.tic_irq && s_q.tic_en) ||
                       (wake_in.serial_irq && s_q.serial_wake_enable) ||
                       (!wake_in.external_interrupt_zero_n &&
                        s_q.ext_int_zero_wake_enable);

   // ************************************************************
   // next state: mode machine, register writes, outputs
   // ************************************************************
   always_comb begin
      s_d = s_q;
      s_d.pwr.resume = 1'b0;
      s_d.rsp.pready = 1'b1;
      // zero wait state slave: read data and error are set up in the setup
      // phase so they come straight from flops in the access phase
      if (setup_ph) begin
         s_d.rsp.pslverr = !mapped;
         unique case (apb_req.paddr)
            OFS_POWER_CTRL: s_d.rsp.prdata = power_control_reg;
            OFS_PLL_CTRL: s_d.rsp.prdata = pll_control_reg;
            OFS_STATUS: s_d.rsp.prdata = status_reg;
            default: s_d.rsp.prdata = 32'h0000_0000;
         endcase
      end
      // wake handling first, so a write in the same cycle wins
      unique case (s_q.mode)
         MODE_NORMAL: begin
            if (s_q.pdown_req) begin
               s_d.mode = MODE_PDOWN;
            end else if (s_q.idle_req) begin
               s_d.mode = MODE_IDLE;
            end
         end
         MODE_IDLE: begin
            if (wake_in.irq_any) begin
               s_d.mode = MODE_NORMAL;
               s_d.idle_req = 1'b0;
               s_d.pwr.resume = 1'b1;
               s_d.cause = CAUSE_IRQ;
            end
         end
         MODE_PDOWN: begin
            if (pdown_wake) begin
               s_d.mode = MODE_NORMAL;
               s_d.idle_req = 1'b0;
               s_d.pdown_req = 1'b0;
               s_d.pwr.resume = 1'b1;
               s_d.cause = wake_in.tic_irq && s_q.tic_en ? CAUSE_TIC : CAUSE_PIN;
            end
         end
         default: s_d.mode = MODE_NORMAL;
      endcase
      if (access_ph && apb_req.pwrite && mapped) begin
         if (apb_req.paddr == OFS_POWER_CTRL) begin
            s_d.idle_req = apb_req.pwdata[BIT_IDLE_REQ];
            s_d.pdown_req = apb_req.pwdata[BIT_PDOWN_REQ];
            s_d.serial_wake_enable = apb_req.pwdata[BIT_SERIAL_WAKE];
            s_d.ext_int_zero_wake_enable = apb_req.pwdata[BIT_EXT_WAKE];
         end else if (apb_req.paddr == OFS_PLL_CTRL) begin
            s_d.oscillator_halt_bit = apb_req.pwdata[BIT_OSC_HALT];
            s_d.tic_en = apb_req.pwdata[BIT_TIC_EN];
         end
      end
      // a reset overrides any pending wake or write
      if (soft_rst) begin
         s_d.mode = MODE_NORMAL;
         s_d.idle_req = POWER_CTRL_RESET[BIT_IDLE_REQ];
         s_d.pdown_req = POWER_CTRL_RESET[BIT_PDOWN_REQ];
         s_d.serial_wake_enable = POWER_CTRL_RESET[BIT_SERIAL_WAKE];
         s_d.ext_int_zero_wake_enable = POWER_CTRL_RESET[BIT_EXT_WAKE];
         s_d.oscillator_halt_bit = PLL_CTRL_RESET[BIT_OSC_HALT];
         s_d.tic_en = PLL_CTRL_RESET[BIT_TIC_EN];
         s_d.cause = CAUSE_NONE;
         s_d.pwr.resume = 1'b0;
      end
      // outputs follow the next mode so they leave the flops in step with it
      s_d.pwr.core_clk_en = s_d.mode == MODE_NORMAL;
      s_d.pwr.periph_clk_en = s_d.mode != MODE_PDOWN;
      s_d.pwr.pll_en = s_d.mode != MODE_PDOWN;
      s_d.pwr.osc_en = !(s_d.mode == MODE_PDOWN && s_d.oscillator_halt_bit);
      s_d.pwr.tic_clk_en = s_d.pwr.osc_en && s_d.tic_en;
      s_d.pwr.port_hold = s_d.mode != MODE_NORMAL;
      s_d.pwr.dac_hiz = s_d.mode == MODE_PDOWN;
      // idle and power-down never reset the core, so its state survives
      s_d.pwr.core_rst_n = !soft_rst;
   end

   // ************************************************************
   // state register
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '{mode: MODE_NORMAL, idle_req: 1'b0, pdown_req: 1'b0,
                  serial_wake_enable: 1'b0, ext_int_zero_wake_enable: 1'b0,
                  oscillator_halt_bit: 1'b0, tic_en: 1'b0, cause: CAUSE_NONE,
                  rsp: '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000},
                  pwr: '{core_clk_en: 1'b0, periph_clk_en: 1'b0, pll_en: 1'b1,
                         osc_en: 1'b1, tic_clk_en: 1'b0, port_hold: 1'b0,
                         dac_hiz: 1'b0, core_rst_n: 1'b0, resume: 1'b0}};
      end else begin
         s_q <= s_d;
      end
   end

   assign apb_rsp = s_q.rsp;
   assign pwr_out = s_q.pwr;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_resumed;
      s_q.mode == MODE_NORMAL && pwr_out.resume && pwr_out.core_rst_n;
   endsequence

   sequence s_back_to_run;
      s_resumed ##1 pwr_out.core_clk_en && !pwr_out.resume;
   endsequence

   property p_enter_modes;
      s_q.mode == MODE_NORMAL && s_q.idle_req && !s_q.pdown_req && !soft_rst
      |=> s_q.mode == MODE_IDLE && !pwr_out.core_clk_en;
   endproperty
   a_enter_modes: assert property (p_enter_modes)
      else $error("idle request did not enter idle");

   property p_idle_clocks;
      s_q.mode == MODE_IDLE |-> !pwr_out.core_clk_en && pwr_out.periph_clk_en &&
         pwr_out.osc_en && pwr_out.port_hold && !pwr_out.dac_hiz && pwr_out.core_rst_n;
   endproperty
   a_idle_clocks: assert property (p_idle_clocks)
      else $error("wrong clock or pin state in idle");

   property p_pdown_outputs;
      s_q.mode == MODE_PDOWN |-> !pwr_out.pll_en && !pwr_out.core_clk_en &&
         !pwr_out.periph_clk_en && pwr_out.dac_hiz && pwr_out.port_hold;
   endproperty
   a_pdown_outputs: assert property (p_pdown_outputs)
      else $error("wrong clock or pin state in power-down");

   property p_osc_choice;
      s_q.mode == MODE_PDOWN |-> pwr_out.osc_en == !s_q.oscillator_halt_bit &&
         pwr_out.tic_clk_en == (s_q.tic_en && !s_q.oscillator_halt_bit);
   endproperty
   a_osc_choice: assert property (p_osc_choice)
      else $error("oscillator or interval clock wrong in power-down");

   property p_idle_wake;
      s_q.mode == MODE_IDLE && wake_in.irq_any && !soft_rst
      |=> s_back_to_run and !s_q.idle_req;
   endproperty
   a_idle_wake: assert property (p_idle_wake)
      else $error("enabled interrupt did not end idle");

   property p_tic_wake;
      s_q.mode == MODE_PDOWN && wake_in.tic_irq && s_q.tic_en && !soft_rst
      |=> s_resumed ##0 s_q.cause == CAUSE_TIC && !s_q.pdown_req;
   endproperty
   a_tic_wake: assert property (p_tic_wake)
      else $error("interval counter interrupt did not end power-down");

   property p_serial_gated;
      s_q.mode == MODE_PDOWN && wake_in.serial_irq && !s_q.serial_wake_enable &&
      !(wake_in.tic_irq && s_q.tic_en) && wake_in.external_interrupt_zero_n && !soft_rst
      |=> s_q.mode == MODE_PDOWN;
   endproperty
   a_serial_gated: assert property (p_serial_gated)
      else $error("serial interrupt woke without its enable");

   property p_ext_wake;
      s_q.mode == MODE_PDOWN && s_q.ext_int_zero_wake_enable &&
      !wake_in.external_interrupt_zero_n && !soft_rst |=> s_back_to_run;
   endproperty
   a_ext_wake: assert property (p_ext_wake)
      else $error("interrupt zero did not end power-down");

   property p_reset_pin;
      !wake_in.reset_pin_n |=> s_q.mode == MODE_NORMAL && !pwr_out.core_rst_n &&
         !s_q.pdown_req && !s_q.idle_req;
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("reset did not return registers to defaults");

endmodule

`default_nettype wire

// *** pmc_power_mode_controller_tb_top.sv ***
/*
 * pmc_power_mode_controller_tb_top: self-checking bench of the power mode
 * controller with a state model written from the mode rules.
 * assumes pmc_wake_src stands for every wake and supply source.
 */
`timescale 1ns/1ns
`default_nettype none

module pmc_power_mode_controller_tb_top;
   import pmc_pkg::*;

   localparam int POR = 16;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic power_good = 1'b1;
   logic [4:0] want = 5'h00;
   logic sup_hi;
   logic sup_lo;
   pmc_apb_req_type req = '0;
   pmc_apb_rsp_type rsp;
   pmc_wake_in_type wake_in;
   pmc_power_out_type pwr;
   int mismatches = 0;
   int compares = 0;
   int seed = 32'h0000_20ea;
   int m_mode = 0;
   int m_halt = 0;
   int m_tic = 0;
   logic [31:0] rd;
   logic err;

   // ************************************************************
   // clock, design and partner
   // ************************************************************
   always #5 pclk = ~pclk;

   pmc_power_mode_controller #(.POR_CYCLES(POR)) dut (.pclk(pclk), .presetn(presetn),
      .apb_req(req), .apb_rsp(rsp), .wake_in(wake_in), .supply_above_hi(sup_hi),
      .supply_above_lo(sup_lo), .pwr_out(pwr));

   pmc_wake_src src (.pclk(pclk), .want(want), .power_good(power_good), .pwr_out(pwr),
      .wake_in(wake_in), .supply_above_hi(sup_hi), .supply_above_lo(sup_lo));

   // ************************************************************
   // checking helpers
   // ************************************************************
   task automatic stop_test;
      if (mismatches == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic hang(input string what);
      mismatches++;
      $display("mismatch at %0t: %s timed out", $time, what);
      stop_test();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // model of the gate and hold outputs for the current mode
   function automatic logic [31:0] exp_pwr();
      pmc_power_out_type e;
      e.core_clk_en = (m_mode == 0);
      e.periph_clk_en = (m_mode != 2);
      e.pll_en = (m_mode != 2);
      e.osc_en = !(m_mode == 2 && m_halt == 1);
      e.tic_clk_en = e.osc_en && (m_tic == 1);
      e.port_hold = (m_mode != 0);
      e.dac_hiz = (m_mode == 2);
      e.core_rst_n = 1'b1;
      e.resume = 1'b0;
      return 32'(e);
   endfunction

   task automatic settle(input int n);
      repeat (n) @(negedge pclk);
   endtask

   // one apb transfer; starts on a rising edge so no signal is driven twice
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (rsp.pready !== 1'b1 && n < 20);
      if (rsp.pready !== 1'b1) hang("apb ready");
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic e_err);
      apb(1'b0, a, '0);
      chk(rd, exp, "read data");
      chk(32'(err), 32'(e_err), "slave error");
   endtask

   task automatic drive_want(input logic [4:0] v);
      @(posedge pclk);
      want <= v;
   endtask

   // resume is a one-cycle pulse, so it is looked for at every negedge
   task automatic wait_resume(input int lim, output bit seen);
      seen = 0;
      for (int i = 0; i < lim && !seen; i++) begin
         @(negedge pclk);
         seen = (pwr.resume === 1'b1);
      end
   endtask

   task automatic wait_rst(output int n);
      n = 0;
      while (pwr.core_rst_n !== 1'b1 && n < POR + 20) begin
         @(negedge pclk);
         n++;
      end
      if (n >= POR + 20) hang("core reset release");
   endtask

   // a hang anywhere ends the run through the same report
   initial begin
      repeat (20000) @(posedge pclk);
      hang("whole run");
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      bit seen;
      int n;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      wait_rst(n);
      chk(32'(n >= POR + 1 && n <= POR + 2), 32'h0000_0001, "por release");
      rdchk(OFS_POWER_CTRL, POWER_CTRL_RESET, 1'b0);
      rdchk(OFS_PLL_CTRL, PLL_CTRL_RESET, 1'b0);
      rdchk(OFS_STATUS, 32'h0000_0000, 1'b0);
      rdchk(8'h0C, 32'h0000_0000, 1'b1);
      chk(32'(pwr), exp_pwr(), "normal outputs");

      // idle with both wake enables set; stray high bits are ignored
      apb(1'b1, OFS_POWER_CTRL, ($random(seed) & 32'hFFFF_FFF0) | 32'h0000_000D);
      m_mode = 1;
      settle(2);
      chk(32'(pwr), exp_pwr(), "idle outputs");
      rdchk(OFS_STATUS, 32'h0000_0001, 1'b0);
      drive_want(5'h04);
      wait_resume(8, seen);
      chk(32'(seen), 32'h0000_0000, "serial woke idle");
      drive_want(5'h14);
      wait_resume(8, seen);
      chk(32'(seen), 32'h0000_0001, "irq wake from idle");
      m_mode = 0;
      settle(1);
      chk(32'(pwr), exp_pwr(), "after idle wake");
      drive_want(5'h00);
      rdchk(OFS_POWER_CTRL, 32'h0000_000C, 1'b0);
      rdchk(OFS_STATUS, 32'h0000_0010, 1'b0);

      // power-down per source, with its enable off and then on
      for (int s = 0; s < 3; s++) begin
         for (int en = 0; en < 2; en++) begin
            m_halt = $random(seed) & 1;
            m_tic = (s == 0) ? en : 1;
            apb(1'b1, OFS_PLL_CTRL, 32'(2 * m_tic + m_halt));
            apb(1'b1, OFS_POWER_CTRL, 32'(2 + ((s == 1 && en == 1) ? 4 : 0)
               + ((s == 2 && en == 1) ? 8 : 0)));
            m_mode = 2;
            settle(2);
            chk(32'(pwr), exp_pwr(), "power-down outputs");
            drive_want(5'h10 | (5'h08 >> s));
            wait_resume(12, seen);
            chk(32'(seen), 32'(en), "power-down wake");
            if (seen) begin
               m_mode = 0;
               settle(1);
               chk(32'(pwr), exp_pwr(), "after power-down wake");
               drive_want(5'h00);
               rdchk(OFS_STATUS, (s == 0) ? 32'h0000_0020 : 32'h0000_0030, 1'b0);
               rdchk(OFS_POWER_CTRL, 32'(4 * s), 1'b0);
            end else begin
               drive_want(5'h01);
               settle(3);
               chk(32'({pwr.core_rst_n, pwr.dac_hiz}), 32'h0000_0000, "reset pin in pdown");
               drive_want(5'h00);
               wait_rst(n);
               chk(32'(n <= 3), 32'h0000_0001, "reset pin release");
               m_mode = 0;
               m_halt = 0;
               m_tic = 0;
               rdchk(OFS_POWER_CTRL, POWER_CTRL_RESET, 1'b0);
               rdchk(OFS_PLL_CTRL, PLL_CTRL_RESET, 1'b0);
               chk(32'(pwr), exp_pwr(), "after reset pin");
            end
         end
      end

      // supply cycling: reset while low, then the por delay again
      apb(1'b1, OFS_PLL_CTRL, 32'h0000_0002);
      @(posedge pclk);
      power_good <= 1'b0;
      settle(4);
      chk(32'(pwr.core_rst_n), 32'h0000_0000, "reset on falling supply");
      @(posedge pclk);
      power_good <= 1'b1;
      wait_rst(n);
      chk(32'(n >= POR + 2 && n <= POR + 4), 32'h0000_0001, "power cycle delay");
      rdchk(OFS_PLL_CTRL, PLL_CTRL_RESET, 1'b0);
      stop_test();
   end
endmodule

`default_nettype wire

// *** pmc_wake_src.sv ***
/*
 * pmc_wake_src: model of the parties outside the power mode controller:
 * interrupt sources, the reset pin and the supply comparators.
 * assumes bench commands change just after a rising pclk edge.
 */
`timescale 1ns/1ns
`default_nettype none

module pmc_wake_src #(
   parameter int GUARD = 4
) (
   input wire logic pclk,                           // system clock
   input wire logic [4:0] want,                     // irq, tic, serial, int zero, reset pin
   input wire logic power_good,                     // supply on command
   input wire pmc_pkg::pmc_power_out_type pwr_out,  // device power state
   output pmc_pkg::pmc_wake_in_type wake_in,        // wake lines to device
   output logic supply_above_hi,                    // upper comparator
   output logic supply_above_lo                     // lower comparator
);
   import pmc_pkg::*;

   int pd_cycles = 0;

   // ************************************************************
   // wake sources
   // ************************************************************
   // all sources quiet and the supply off until the bench asks
   initial begin
      wake_in = 5'h03;
      supply_above_hi = 1'b0;
      supply_above_lo = 1'b0;
   end

   // time spent in power-down, so interrupt zero never falls near entry
   always @(posedge pclk) begin
      pd_cycles <= pwr_out.dac_hiz ? pd_cycles + 1 : 0;
   end

   // levels follow the commands one edge later, like a real pin sync
   always @(posedge pclk) begin
      wake_in.irq_any <= want[4];
      wake_in.tic_irq <= want[3];
      wake_in.serial_irq <= want[2];
      wake_in.external_interrupt_zero_n <= !(want[1] && pd_cycles >= GUARD);
      wake_in.reset_pin_n <= !want[0];
   end

   // ************************************************************
   // supply
   // ************************************************************
   // the lower level rises first and falls last, as a real ramp does
   always @(posedge pclk) begin
      supply_above_lo <= power_good || supply_above_hi;
      supply_above_hi <= power_good && supply_above_lo;
   end
endmodule

`default_nettype wire
